// File: logic/uhds_pkg.sv
`default_nettype none
package uhds_pkg;
  localparam int NSLOT = 32;
  localparam int SLOT_W = 5;
  localparam int NTYPE = 3;
  localparam int MEM_AW = 9;
  localparam logic [4:0] SLOT_LAST = 5'h1f;
  // Qword base of each list in descriptor memory, four qwords per slot
  localparam logic [2:0][8:0] LIST_BASE = {9'h100, 9'h080, 9'h000};
  localparam logic [1:0] QW_CTRL = 2'h0;
  localparam logic [1:0] QW_STAT = 2'h1;
  localparam logic [1:0] QW_LINK = 2'h2;
  // Bit positions inside the 64-bit descriptor qwords
  localparam int F_VALID = 0;
  localparam int F_LEN_LO = 3;
  localparam int F_ADDR_LO = 8;
  localparam int F_BYTES_LO = 32;
  localparam int F_NAK_LO = 51;
  localparam int F_CERR_LO = 55;
  localparam int F_TOGGLE = 57;
  localparam int F_PING = 58;
  localparam int F_XERR = 60;
  localparam int F_BABBLE = 61;
  localparam int F_HALT = 62;
  localparam int F_ACTIVE = 63;
  localparam int F_JUMP = 5;
  localparam int F_PTR_LO = 0;
  localparam logic [1:0] RETRY_MAX = 2'h3;
  localparam int UFRAME_NS = 125000;
  localparam int CLK_PERIOD_NS = 40;
  localparam int UFRAME_CYC = UFRAME_NS / CLK_PERIOD_NS;
  localparam logic [11:0] UF_LAST = 12'(UFRAME_CYC - 1);
  localparam logic [3:0] LAT_MAX = 4'hf;

  typedef enum logic [1:0] {
    LIST_ISOCHRONOUS = 2'h0,
    LIST_PERIODIC_INTERRUPT = 2'h1,
    LIST_ASYNC = 2'h2
  } uhds_list_t;

  typedef enum logic [8:0] {
    ST_IDLE = 9'h001,
    ST_FETCH = 9'h002,
    ST_LOAD = 9'h004,
    ST_DECIDE = 9'h008,
    ST_ISSUE = 9'h010,
    ST_WAIT = 9'h020,
    ST_WB = 9'h040,
    ST_WBV = 9'h080,
    ST_ADV = 9'h100
  } uhds_state_t;

  typedef struct packed {
    uhds_list_t list;
    logic [4:0] slot;
    logic [15:0] addr;
    logic [14:0] len;
    logic data_toggle;
    logic ping;
  } uhds_xfer_t;

  typedef struct packed {
    logic babble;
    logic xact_err;
    logic halt;
    logic data_toggle;
    logic ping;
    logic [3:0] nak_retry_count;
    logic [14:0] bytes;
  } uhds_res_t;
endpackage
`default_nettype wire

// File: logic/uhds_sched.sv
`timescale 1ns/100ps
`default_nettype none

module uhds_fifo2 #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  logic [1:0][W-1:0] buf_q;
  logic wr_q;
  logic rd_q;
  logic [1:0] cnt_q;
  logic push;
  logic pop;

  assign in_ready = (cnt_q != 2'h2);
  assign out_valid = (cnt_q != 2'h0);
  assign out_data = buf_q[rd_q];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      buf_q <= '0;
    end else if (push) begin
      buf_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      if (push) wr_q <= ~wr_q;
      if (pop) rd_q <= ~rd_q;
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule // uhds_fifo2

////////////////////////////////////////////////////////////////////////////////

module uhds_sched (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Control
  input wire logic sched_en,
  input wire logic [uhds_pkg::NTYPE-1:0][uhds_pkg::NSLOT-1:0] skip_map,
  input wire logic [uhds_pkg::NTYPE-1:0][uhds_pkg::NSLOT-1:0] final_slot_marker,
  input wire logic [uhds_pkg::NTYPE-1:0][uhds_pkg::NSLOT-1:0] irq_or_mask,
  input wire logic [uhds_pkg::NTYPE-1:0][uhds_pkg::NSLOT-1:0] irq_and_mask,
  input wire logic [uhds_pkg::NTYPE-1:0][uhds_pkg::NSLOT-1:0] done_clr,
  input wire logic [3:0] irq_latency,
  input wire logic [3:0] irq_clr,
  // Status
  output logic [uhds_pkg::NTYPE-1:0][uhds_pkg::NSLOT-1:0] done_map,
  output logic [3:0] irq,
  output logic busy,
  // Shared descriptor memory, read data one cycle after mem_rd_en
  output logic mem_rd_en,
  output logic mem_wr_en,
  output logic [uhds_pkg::MEM_AW-1:0] mem_addr,
  output logic [63:0] mem_wr_data,
  input wire logic [63:0] mem_rd_data,
  // Transaction engine
  output logic xfer_valid,
  input wire logic xfer_ready,
  output uhds_pkg::uhds_xfer_t xfer,
  input wire logic res_valid,
  output logic res_ready,
  input wire uhds_pkg::uhds_res_t res
);
  import uhds_pkg::*;
  default clocking cb_sys @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);

  uhds_state_t state_q, state_d;
  uhds_list_t list_q;
  logic [SLOT_W-1:0] slot_q;
  logic [1:0] qw_q;
  logic [63:0] ctrl_q, stat_q, link_q;
  logic [1:0] retry_q;
  uhds_res_t res_q;
  logic [11:0] uf_cnt_q;
  logic uf_tick;
  logic [NTYPE-1:0][NSLOT-1:0] done_q, done_set;
  logic [3:0] pend_q, lat_q, irq_q, ev, release_v;
  logic cur_skip, cur_last, cur_valid, cur_active, cur_jump, exec_ok;
  logic [SLOT_W-1:0] cur_ptr, next_slot;
  logic jump_take, list_end, err_retry, fin, fifo_in_ready;
  logic [63:0] wb_stat, wb_ctrl;
  logic [1:0] qsel;
  uhds_xfer_t xfer_d;
  logic [$bits(uhds_xfer_t)-1:0] fifo_out;

  ////////////////////////////////////////////////////////////////////////////
  // Microframe timer paces walks and the frame interrupt

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      uf_cnt_q <= 12'h000;
    end else if (uf_cnt_q == UF_LAST) begin
      uf_cnt_q <= 12'h000;
    end else begin
      uf_cnt_q <= uf_cnt_q + 12'h001;
    end
  end

  assign uf_tick = (uf_cnt_q == UF_LAST);

  ////////////////////////////////////////////////////////////////////////////
  // Descriptor decode

  assign cur_skip = skip_map[list_q][slot_q];
  assign cur_last = final_slot_marker[list_q][slot_q];
  assign cur_valid = ctrl_q[F_VALID];
  // Active still set means the descriptor is not yet done
  assign cur_active = stat_q[F_ACTIVE];
  assign cur_jump = link_q[F_JUMP];
  assign cur_ptr = link_q[F_PTR_LO +: SLOT_W];
  assign exec_ok = cur_valid & cur_active & ~cur_skip;
  // A backward pointer would loop forever, so it falls back to increment
  assign jump_take = cur_jump & ~cur_skip & (cur_ptr > slot_q);
  assign list_end = cur_last | (slot_q == SLOT_LAST);
  assign next_slot = jump_take ? cur_ptr : slot_q + 5'h01;
  // Babble ends the descriptor even when an error retry is still owed
  assign err_retry = res_q.xact_err & ~res_q.babble & (retry_q != RETRY_MAX);
  assign fin = (state_q == ST_WB) & ~err_retry;

  ////////////////////////////////////////////////////////////////////////////
  // Walk state machine

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: if (uf_tick && sched_en) state_d = ST_FETCH;
      ST_FETCH: state_d = ST_LOAD;
      ST_LOAD: state_d = (qw_q == QW_LINK) ? ST_DECIDE : ST_FETCH;
      ST_DECIDE: state_d = exec_ok ? ST_ISSUE : ST_ADV;
      ST_ISSUE: if (fifo_in_ready) state_d = ST_WAIT;
      ST_WAIT: if (res_valid) state_d = ST_WB;
      ST_WB: state_d = err_retry ? ST_ISSUE : (res_q.babble || res_q.xact_err) ? ST_WBV : ST_ADV;
      ST_WBV: state_d = ST_ADV;
      ST_ADV: state_d = (!sched_en || (list_end && list_q == LIST_ASYNC)) ? ST_IDLE : ST_FETCH;
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // List order and slot position
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      list_q <= LIST_ISOCHRONOUS;
      slot_q <= '0;
    end else if (state_q == ST_IDLE) begin
      list_q <= LIST_ISOCHRONOUS;
      slot_q <= '0;
    end else if (state_q == ST_ADV) begin
      if (list_end) begin
        list_q <= (list_q == LIST_ISOCHRONOUS) ? LIST_PERIODIC_INTERRUPT : LIST_ASYNC;
        slot_q <= '0;
      end else begin
        slot_q <= next_slot;
      end
    end
  end

  // Descriptor fetch, three qwords per slot
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      qw_q <= 2'h0;
      ctrl_q <= '0;
      stat_q <= '0;
      link_q <= '0;
    end else if (state_q == ST_IDLE || state_q == ST_ADV) begin
      qw_q <= 2'h0;
    end else if (state_q == ST_LOAD) begin
      qw_q <= qw_q + 2'h1;
      unique case (qw_q)
        QW_CTRL: ctrl_q <= mem_rd_data;
        QW_STAT: stat_q <= mem_rd_data;
        default: link_q <= mem_rd_data;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      retry_q <= 2'h0;
      res_q <= '0;
    end else begin
      if (state_q == ST_ADV) retry_q <= 2'h0;
      else if (state_q == ST_WB && err_retry) retry_q <= retry_q + 2'h1;
      if (state_q == ST_WAIT && res_valid) res_q <= res;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status write-back

  always_comb begin
    wb_stat = stat_q;
    // Active stays up only while a retry is still owed
    wb_stat[F_ACTIVE] = err_retry;
    wb_stat[F_HALT] = res_q.halt;
    wb_stat[F_BABBLE] = res_q.babble;
    wb_stat[F_XERR] = res_q.xact_err;
    wb_stat[F_PING] = res_q.ping;
    wb_stat[F_TOGGLE] = res_q.data_toggle;
    wb_stat[F_CERR_LO +: 2] = retry_q;
    wb_stat[F_NAK_LO +: 4] = res_q.nak_retry_count;
    // Wraps past 32 kB - 1; the engine never moves more than that
    wb_stat[F_BYTES_LO +: 15] = stat_q[F_BYTES_LO +: 15] + res_q.bytes;
    wb_ctrl = ctrl_q;
    wb_ctrl[F_VALID] = 1'b0;
  end

  assign qsel = (state_q == ST_WB) ? QW_STAT : (state_q == ST_WBV) ? QW_CTRL : qw_q;
  assign mem_addr = LIST_BASE[list_q] + {2'b00, slot_q, qsel};
  assign mem_rd_en = (state_q == ST_FETCH);
  assign mem_wr_en = (state_q == ST_WB) | (state_q == ST_WBV);
  assign mem_wr_data = (state_q == ST_WBV) ? wb_ctrl : wb_stat;

  ////////////////////////////////////////////////////////////////////////////
  // Transfer requests through a two-entry buffer

  always_comb begin
    xfer_d.list = list_q;
    xfer_d.slot = slot_q;
    xfer_d.addr = stat_q[F_ADDR_LO +: 16];
    xfer_d.len = ctrl_q[F_LEN_LO +: 15];
    xfer_d.data_toggle = stat_q[F_TOGGLE];
    xfer_d.ping = stat_q[F_PING];
  end

  uhds_fifo2 #(.W($bits(uhds_xfer_t))) uhds_fifo2_inst (
    .clk(sys_clk),
    .rstn(rstn),
    .in_valid(state_q == ST_ISSUE),
    .in_ready(fifo_in_ready),
    .in_data(xfer_d),
    .out_valid(xfer_valid),
    .out_ready(xfer_ready),
    .out_data(fifo_out)
  );

  assign xfer = uhds_xfer_t'(fifo_out);
  assign res_ready = (state_q == ST_WAIT);
  assign busy = (state_q != ST_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  // Done maps and interrupts

  always_comb begin
    done_set = '0;
    ev = 4'h0;
    if (fin) begin
      done_set[list_q][slot_q] = 1'b1;
      ev[list_q] = irq_or_mask[list_q][slot_q] |
                   (irq_and_mask[list_q][slot_q] &
                    (((done_q[list_q] | done_set[list_q]) & irq_and_mask[list_q]) == irq_and_mask[list_q]));
    end
    ev[3] = uf_tick;
  end

  // A completion in the clearing cycle survives
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      done_q <= '0;
    end else begin
      done_q <= (done_q & ~done_clr) | done_set;
    end
  end

  assign release_v = (pend_q != 4'h0 && lat_q >= irq_latency) ? pend_q : 4'h0;

  // Latency counted in whole microframes since the oldest pending event
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pend_q <= 4'h0;
      lat_q <= 4'h0;
    end else begin
      pend_q <= (pend_q & ~release_v) | ev;
      if (pend_q == 4'h0 || release_v != 4'h0) lat_q <= 4'h0;
      else if (uf_tick && lat_q != LAT_MAX) lat_q <= lat_q + 4'h1;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      irq_q <= 4'h0;
    end else begin
      irq_q <= (irq_q & ~irq_clr) | release_v;
    end
  end

  assign done_map = done_q;
  assign irq = irq_q;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  property p_list_order;
    state_q == ST_ADV && list_end && list_q != LIST_ASYNC |=>
      2'(list_q) == 2'($past(list_q)) + 2'h1 && slot_q == 5'h00;
  endproperty
  a_list_order: assert property (p_list_order) else $error("list order broken");
  property p_forward;
    state_q == ST_ADV && !list_end |=> slot_q > $past(slot_q);
  endproperty
  a_forward: assert property (p_forward) else $error("slot moved backward");
  property p_branch;
    state_q == ST_ADV && !list_end && cur_jump && !cur_skip && cur_ptr > slot_q |=> slot_q == $past(cur_ptr);
  endproperty
  a_branch: assert property (p_branch) else $error("branch target missed");
  property p_skip;
    state_q == ST_DECIDE && cur_skip && !list_end |=> state_q == ST_ADV ##1 slot_q == $past(slot_q, 2) + 5'h01;
  endproperty
  a_skip: assert property (p_skip) else $error("skip not honoured");
  property p_exec;
    state_q == ST_ISSUE |-> cur_valid && cur_active && !cur_skip;
  endproperty
  a_exec: assert property (p_exec) else $error("inactive descriptor issued");
  property p_done;
    fin |-> !mem_wr_data[F_ACTIVE] ##1 done_map[$past(list_q)][$past(slot_q)];
  endproperty
  a_done: assert property (p_done) else $error("done bit not set");
  property p_retry;
    state_q == ST_WB && err_retry |-> mem_wr_data[F_XERR] && mem_wr_data[F_ACTIVE] ##1 state_q == ST_ISSUE;
  endproperty
  a_retry: assert property (p_retry) else $error("error retry missing");
  property p_babble;
    state_q == ST_WB && res_q.babble |-> !mem_wr_data[F_ACTIVE] ##1 mem_wr_en && !mem_wr_data[F_VALID];
  endproperty
  a_babble: assert property (p_babble) else $error("babble flags wrong");
  property p_sof;
    uf_tick && irq_latency == 4'h0 |-> ##[1:2] irq[3];
  endproperty
  a_sof: assert property (p_sof) else $error("frame interrupt late");
  c_full_walk: cover property (state_q == ST_ADV && list_end && list_q == LIST_ASYNC);
  c_retry: cover property (state_q == ST_WB && err_retry);
  c_jump: cover property (state_q == ST_ADV && jump_take && !list_end);
endmodule // uhds_sched

`default_nettype wire

// File: test/uhds_partner.sv
`timescale 1ns/100ps
`default_nettype none
module uhds_partner (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Descriptor memory
  input wire logic mem_rd_en,
  input wire logic mem_wr_en,
  input wire logic [8:0] mem_addr,
  input wire logic [63:0] mem_wr_data,
  output logic [63:0] mem_rd_data,
  // Transaction engine
  input wire logic [3:0] stall,
  input wire logic xfer_valid,
  output logic xfer_ready,
  input wire uhds_pkg::uhds_xfer_t xfer,
  output logic res_valid,
  input wire logic res_ready,
  output uhds_pkg::uhds_res_t res
);
  import uhds_pkg::*;
  logic [63:0] mem [0:383];
  // Outcome per slot: 0 ok, 1 error, 2 babble
  logic [1:0] mode [0:2][0:31];
  logic [4:0] cnt;
  logic [1:0] m;
  uhds_xfer_t cur;
  assign m = mode[cur.list][cur.slot];

  // Released data bus toggles so a stale word never passes for an answer
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      mem_rd_data <= '0;
    end else begin
      if (mem_wr_en) mem[mem_addr] <= mem_wr_data;
      mem_rd_data <= mem_rd_en ? mem[mem_addr] : ~mem_rd_data;
    end
  end

  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      xfer_ready <= 1'b0;
      res_valid <= 1'b0;
      cnt <= 5'h0;
      cur <= '0;
      res <= '0;
    end else if (xfer_valid && xfer_ready) begin
      xfer_ready <= 1'b0;
      cur <= xfer;
      cnt <= {1'b0, stall} + 5'h1;
    end else if (cnt > 5'h1) begin
      cnt <= cnt - 5'h1;
    end else if (cnt == 5'h1) begin
      cnt <= 5'h0;
      res_valid <= 1'b1;
      res <= '{babble: m == 2'h2, xact_err: m == 2'h1, halt: 1'b0,
               data_toggle: cur.data_toggle ^ (m == 2'h0), ping: cur.ping,
               nak_retry_count: 4'h0, bytes: (m == 2'h0) ? cur.len : 15'h0};
    end else if (res_valid) begin
      res_valid <= !res_ready;
    end else begin
      // Idle result lines carry a moving pattern
      res <= ~res;
      xfer_ready <= xfer_valid;
    end
  end
endmodule // uhds_partner
`default_nettype wire

// File: test/uhds_sched_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module uhds_sched_tb_top;
  import uhds_pkg::*;
  logic sys_clk, rstn, sched_en, busy, mem_rd_en, mem_wr_en;
  logic xfer_valid, xfer_ready, res_valid, res_ready;
  logic [NTYPE-1:0][NSLOT-1:0] skip_map, final_slot_marker, irq_or_mask, irq_and_mask, done_clr, done_map;
  logic [3:0] irq_latency, irq_clr, irq, stall;
  logic [MEM_AW-1:0] mem_addr;
  logic [63:0] mem_wr_data, mem_rd_data;
  uhds_xfer_t xfer;
  uhds_xfer_t expq[$];
  uhds_xfer_t dsc [0:2][0:31];
  uhds_res_t res;
  int error_cnt = 0;
  int n_checks = 0;
  logic [31:0] rng = 32'h0001789e;

  uhds_sched uhds_sched_inst (.sys_clk, .rstn, .sched_en, .skip_map, .final_slot_marker, .irq_or_mask,
    .irq_and_mask, .done_clr, .irq_latency, .irq_clr, .done_map, .irq, .busy, .mem_rd_en, .mem_wr_en,
    .mem_addr, .mem_wr_data, .mem_rd_data, .xfer_valid, .xfer_ready, .xfer, .res_valid, .res_ready, .res);
  uhds_partner uhds_partner_inst (.sys_clk, .rstn, .mem_rd_en, .mem_wr_en, .mem_addr, .mem_wr_data,
    .mem_rd_data, .stall, .xfer_valid, .xfer_ready, .xfer, .res_valid, .res_ready, .res);

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  function automatic logic [63:0] rd(input int l, input int s, input int w);
    return uhds_partner_inst.mem[LIST_BASE[l] + 9'(s * 4 + w)];
  endfunction

  task automatic tick(input int n = 1);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic chk(input logic [127:0] got, input logic [127:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask

  task automatic cmp_req(input uhds_xfer_t got, input uhds_xfer_t exp);
    chk(128'(got), 128'(exp), "request");
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Random payload reaches the design through the descriptor words
  task automatic put(input int l, input int s, input logic jmp, input logic [4:0] ptr);
    logic [8:0] b;
    rng = xs(rng);
    b = LIST_BASE[l] + 9'(s * 4);
    dsc[l][s] = '{list: uhds_list_t'(l), slot: 5'(s), addr: rng[15:0], len: rng[30:16],
                  data_toggle: rng[31], ping: rng[0]};
    uhds_partner_inst.mem[b] = {46'h0, rng[30:16], 3'h1};
    uhds_partner_inst.mem[b + 9'h1] = {1'b1, 4'h0, rng[0], rng[31], 33'h0, rng[15:0], 8'h0};
    uhds_partner_inst.mem[b + 9'h2] = {58'h0, jmp, ptr};
  endtask

  task automatic ex(input int l, input int s, input int n = 1);
    repeat (n) expq.push_back(dsc[l][s]);
  endtask

  task automatic clr();
    for (int a = 0; a < 384; a++) uhds_partner_inst.mem[a] = 64'h0;
    for (int l = 0; l < 3; l++)
      for (int s = 0; s < 32; s++) uhds_partner_inst.mode[l][s] = 2'h0;
  endtask

  task automatic walk();
    int n;
    n = 0;
    rng = xs(rng);
    stall = rng[3:0];
    sched_en = 1'b1;
    while (busy !== 1'b1 && n < 4000) begin
      tick();
      n++;
    end
    while (busy !== 1'b0 && n < 8000) begin
      tick();
      n++;
    end
    sched_en = 1'b0;
    tick(4);
    if (n >= 8000 || expq.size() != 0) begin
      error_cnt++;
      $display("mismatch at %0t: walk hung or requests missing", $time);
      test_done();
    end
  endtask

  always @(posedge sys_clk) begin
    if (xfer_valid === 1'b1 && xfer_ready === 1'b1)
      cmp_req(xfer, expq.size() > 0 ? expq.pop_front() : uhds_xfer_t'('x));
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [63:0] q;
    int n;
    rstn = 1'b0;
    sched_en = 1'b0;
    skip_map = '0;
    final_slot_marker = '0;
    irq_or_mask = '0;
    irq_and_mask = '0;
    done_clr = '0;
    irq_latency = 4'h0;
    irq_clr = 4'h0;
    stall = 4'h0;
    clr();
    tick(16);
    chk({busy, irq, done_map, xfer_valid, res_ready, mem_rd_en, mem_wr_en}, '0, "reset outputs");
    rstn = 1'b1;
    // Order across lists; skip hides a branch; branch jumps forward; final ends a list
    final_slot_marker[0][6] = 1'b1;
    final_slot_marker[1][31] = 1'b1;
    final_slot_marker[2][0] = 1'b1;
    skip_map[0][1] = 1'b1;
    irq_or_mask[0][5] = 1'b1;
    irq_and_mask[1][31] = 1'b1;
    for (int s = 0; s < 8; s++) put(0, s, s == 1 || s == 2, (s == 1) ? 5'h3 : 5'h5);
    put(1, 5, 1'b0, 5'h0);
    uhds_partner_inst.mem[LIST_BASE[1] + 9'h15][63] = 1'b0;
    put(1, 31, 1'b0, 5'h0);
    put(2, 0, 1'b0, 5'h0);
    ex(0, 0);
    ex(0, 2);
    ex(0, 5);
    ex(0, 6);
    ex(1, 31);
    ex(2, 0);
    walk();
    chk(done_map, 96'h00000001_80000000_00000065, "done map");
    q = rd(0, 5, 1);
    chk({q[63], q[46:32]}, {1'b0, dsc[0][5].len}, "status word");
    chk(irq, 4'hb, "irq");
    irq_clr = 4'hf;
    done_clr = '1;
    tick();
    irq_clr = 4'h0;
    done_clr = '0;
    tick(2);
    chk({irq, done_map}, '0, "cleared status");
    $display("test 1 done");
    // Backward branch, retried error, babble, AND group
    clr();
    skip_map = '0;
    final_slot_marker = '0;
    final_slot_marker[0][11] = 1'b1;
    final_slot_marker[2][3] = 1'b1;
    irq_or_mask = '0;
    irq_and_mask = '0;
    irq_and_mask[2][3:2] = 2'h3;
    put(0, 10, 1'b1, 5'h4);
    put(0, 11, 1'b0, 5'h0);
    for (int s = 1; s < 4; s++) put(2, s, 1'b0, 5'h0);
    uhds_partner_inst.mode[2][1] = 2'h1;
    uhds_partner_inst.mode[2][2] = 2'h2;
    ex(0, 10);
    ex(0, 11);
    ex(2, 1, 4);
    ex(2, 2);
    ex(2, 3);
    walk();
    chk(done_map, 96'h0000000e_00000000_00000c00, "done map");
    chk(irq, 4'hc, "irq");
    q = rd(2, 1, 1);
    chk({q[63], q[60], q[56:55]}, {1'b0, 1'b1, 2'h3}, "error status");
    q = rd(2, 1, 0);
    chk(q[0], 1'b0, "error valid");
    q = rd(2, 2, 1);
    chk({q[63], q[61]}, 2'h1, "babble status");
    q = rd(2, 2, 0);
    chk(q[0], 1'b0, "babble valid");
    q = rd(2, 3, 1);
    chk({q[63], q[57]}, {1'b0, ~dsc[2][3].data_toggle}, "toggle");
    $display("test 2 done");
    // One microframe of latency holds the completion event back
    irq_clr = 4'hf;
    done_clr = '1;
    tick();
    irq_clr = 4'h0;
    done_clr = '0;
    irq_latency = 4'h1;
    irq_and_mask = '0;
    irq_or_mask[2][0] = 1'b1;
    clr();
    put(2, 0, 1'b0, 5'h0);
    ex(2, 0);
    sched_en = 1'b1;
    n = 0;
    while (done_map[2][0] !== 1'b1 && n < 8000) begin
      tick();
      n++;
    end
    chk(done_map[2][0], 1'b1, "completion");
    tick(10);
    chk(irq[2], 1'b0, "early irq");
    while (irq[2] !== 1'b1 && n < 16000) begin
      tick();
      n++;
    end
    sched_en = 1'b0;
    chk(irq[2], 1'b1, "late irq");
    chk(expq.size(), 0, "requests left");
    $display("test 3 done");
    test_done();
  end
endmodule // uhds_sched_tb_top
`default_nettype wire
